// *** hdl/pfsd_packet_fifo.sv ***
// packet mode data path: fifo, byte serializer, framing and pattern detection
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - two data modes: bit-serial on the data pin, or payload through the fifo
// - packet mode adds preamble, pattern, crc, whitening on send; strips them on receive
// - payload limited to 255 bytes with crc, 2047 without, or unlimited
// - one fifo, 64 bytes of 8 bits, shared by send and receive
// - serializer sends fifo bytes msb first at the bit rate
// - serializer gathers received bits and writes whole bytes to the fifo
// - buffer_drained high when the fifo holds nothing, once any pending read has seen select fall
// - after reads buffer_drained updates on select falling edge; host checks it
// - buffer_saturated high exactly when every location is occupied
// - a write into a full fifo sets the overflow flag and is dropped
// - writing one to the overflow flag clears it and empties the fifo
// - frame_tx_done rises once the final serializer bit has been sent
// - buffer level output only re-evaluated on a fifo read, write or flush
// - level output invalid after a full condition until the fifo empties
// - fifo flushed entering receive from low power, receive to send, leaving send
// - fifo kept between standby and sleep and when entering send from any mode but receive
// - fifo kept when leaving receive for standby or sleep
// - detection needs its enable, plus bit sync in bit-serial mode
// - detector shifts bits continuously and flags a pattern match
// - first bit meets bit 7 of first byte, last bit meets bit 0 of last
// - match flag cleared leaving receive or when the fifo empties
module pfsd_packet_fifo #(
	parameter int BIT_DIV = pfsd_pkg::CLK_HZ / pfsd_pkg::BITRATE_BPS
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [2:0] chip_mode,
	input wire logic packet_mode,
	input wire logic bit_sync_enable,
	input wire logic crc_enable,
	input wire logic dc_free_enable,
	input wire logic [7:0] preamble_bytes,
	input wire logic [10:0] payload_length,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	input wire logic host_rd,
	output logic [7:0] host_rdata,
	input wire logic spi_select_n,
	input wire logic overflow_clear,
	input wire logic [5:0] level_threshold,
	input wire logic pattern_detect_enable,
	input wire logic [2:0] pattern_length,
	input wire logic [63:0] pattern_value,
	input wire logic demod_bit,
	input wire logic demod_bit_valid,
	output logic mod_bit,
	output logic mod_bit_strobe,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic buffer_drained,
	output logic buffer_saturated,
	output logic buffer_level_irq,
	output logic buffer_overflow_flag,
	output logic frame_tx_done,
	output logic pattern_match_flag,
	output logic payload_ready,
	output logic crc_ok,
	output logic mode_settled
);
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_PRE = 3'b001, TX_SYNC = 3'b010,
		TX_PAY = 3'b011, TX_CRC = 3'b100, TX_END = 3'b101
	} pfsd_tx_st_t;
	typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_PAY = 2'b01, RX_CRC = 2'b10} pfsd_rx_st_t;

	localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);

	// refuse dividers the bit timing cannot serve
	if (BIT_DIV < 2 || BIT_DIV > 65536) begin : g_div_chk
		$error("BIT_DIV out of range");
	end

	pfsd_mem_if #(.DW(8), .AW(pfsd_pkg::AW)) mif ();
	pfsd_mem #(.DW(8), .AW(pfsd_pkg::AW)) u_mem (.sys_clk(sys_clk), .m(mif));

	logic [6:0] count_r, count_nxt;
	logic [5:0] wr_ptr_r, rd_ptr_r;
	logic [2:0] mode_prev_r;
	logic nss_s1_r, nss_s2_r, nss_s3_r, nss_st_r, din_s1_r, din_s2_r, din_s3_r, din_st_r;
	logic nss_fall, rd_pend_r, gap_r, lvl_r, lvl_valid_r, drained_r, ovf_r, settled_r, leave_tx_r;
	logic mode_chg, flush, full_w, host_push, host_pop, rx_push, push_req, push_ok, pop_ok;
	logic [15:0] div_r;
	logic bit_tick, tx_run, rx_run, tx_load, pay_end, tx_bit_w, done_r, mod_bit_r, strobe_r;
	pfsd_tx_st_t tx_st_r;
	logic [7:0] tx_sr_r, rx_sr_r, rx_byte, host_rdata_r, sync_byte;
	logic [2:0] tx_bit_r, rx_bit_r;
	logic [10:0] tx_cnt_r, rx_cnt_r, eff_len;
	logic [15:0] crc_tx_r, crc_rx_r;
	logic [8:0] wl_tx_r, wl_rx_r;
	pfsd_rx_st_t rx_st_r;
	logic [63:0] pat_sr_r, pat_mask;
	logic [6:0] pat_bits, pat_sh, pat_cnt_r;
	logic det_en, pat_chk_r, pat_hit, match_r, crc_bad_r, crc_ok_r, ready_r, rx_b, sdo_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ************************************************************
	// pin synchronisers and mode tracking
	// ************************************************************
	// three stages; a level counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{nss_s1_r, nss_s2_r, nss_s3_r, nss_st_r} <= 4'hF;
			{din_s1_r, din_s2_r, din_s3_r, din_st_r} <= 4'h0;
		end else begin
			{nss_s1_r, nss_s2_r, nss_s3_r} <= {spi_select_n, nss_s1_r, nss_s2_r};
			{din_s1_r, din_s2_r, din_s3_r} <= {serial_data_pin_in, din_s1_r, din_s2_r};
			if (nss_s2_r == nss_s3_r) nss_st_r <= nss_s3_r;
			if (din_s2_r == din_s3_r) din_st_r <= din_s3_r;
		end
	end
	assign nss_fall = nss_st_r && (nss_s2_r == nss_s3_r) && !nss_s3_r;

	assign mode_chg = chip_mode != mode_prev_r;
	assign tx_run = (chip_mode == pfsd_pkg::MODE_TX) && packet_mode;
	assign rx_run = (chip_mode == pfsd_pkg::MODE_RX) && packet_mode;

	// mode history and the settled flag; leaving send waits for the bit period
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_prev_r <= pfsd_pkg::MODE_SLEEP;
			settled_r <= 1'b1;
			leave_tx_r <= 1'b0;
		end else if (mode_chg) begin
			mode_prev_r <= chip_mode;
			settled_r <= 1'b0;
			leave_tx_r <= mode_prev_r == pfsd_pkg::MODE_TX;
		end else if (!settled_r && (!leave_tx_r || div_r == DIV_LAST)) begin
			settled_r <= 1'b1;
			leave_tx_r <= 1'b0;
		end
	end

	// ************************************************************
	// fifo control
	// ************************************************************
	// flush on entering receive from low power, receive to send, or leaving send
	always_comb begin
		flush = overflow_clear;
		if (mode_chg) begin
			if (mode_prev_r == pfsd_pkg::MODE_TX) flush = 1'b1;
			if (mode_prev_r == pfsd_pkg::MODE_RX && chip_mode == pfsd_pkg::MODE_TX) flush = 1'b1;
			if ((mode_prev_r == pfsd_pkg::MODE_SLEEP || mode_prev_r == pfsd_pkg::MODE_STDBY)
				&& chip_mode == pfsd_pkg::MODE_RX) flush = 1'b1;
		end
	end

	assign full_w = count_r == pfsd_pkg::FULL_CNT;
	assign host_push = host_wr && packet_mode && (chip_mode != pfsd_pkg::MODE_RX);
	assign push_req = host_push || rx_push;
	assign push_ok = push_req && !full_w && !flush;
	assign host_pop = host_rd && packet_mode && (count_r != 7'h00) && !gap_r
		&& (chip_mode != pfsd_pkg::MODE_TX) && !flush;
	assign pop_ok = tx_load || host_pop;

	// byte count, with one shared store for both directions
	always_comb begin
		if (flush) count_nxt = 7'h00;
		else count_nxt = count_r + {6'h00, push_ok} - {6'h00, pop_ok};
	end

	// pointers, count and read gap; other modes keep the contents
	always_ff @(posedge sys_clk) begin
		if (srst || flush) begin
			count_r <= 7'h00;
			wr_ptr_r <= 6'h00;
			rd_ptr_r <= 6'h00;
			gap_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			gap_r <= pop_ok;
			if (push_ok) wr_ptr_r <= wr_ptr_r + 6'h01;
			if (pop_ok) rd_ptr_r <= rd_ptr_r + 6'h01;
		end
	end

	assign mif.wr_en = push_ok;
	assign mif.wr_addr = wr_ptr_r;
	assign mif.wr_data = rx_push ? rx_byte : host_wdata;
	assign mif.rd_addr = rd_ptr_r;

	// host read data capture
	always_ff @(posedge sys_clk) begin
		if (srst) host_rdata_r <= 8'h00;
		else if (host_pop) host_rdata_r <= mif.rd_data;
	end

	// drained holds after a read until the next select falling edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_pend_r <= 1'b0;
			drained_r <= 1'b1;
		end else begin
			rd_pend_r <= host_pop || (rd_pend_r && !nss_fall);
			if (nss_fall || !(rd_pend_r || host_pop)) drained_r <= count_nxt == 7'h00;
		end
	end

	// overflow flag; a new overflow wins over the clear
	always_ff @(posedge sys_clk) begin
		if (srst) ovf_r <= 1'b0;
		else if (push_req && full_w) ovf_r <= 1'b1;
		else if (overflow_clear) ovf_r <= 1'b0;
	end

	// level output: updated on fifo read, write or flush only, suspended from full to empty
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lvl_r <= 1'b0;
			lvl_valid_r <= 1'b1;
		end else begin
			if (push_ok || pop_ok || flush) lvl_r <= count_nxt > {1'b0, level_threshold};
			if (count_nxt == 7'h00) lvl_valid_r <= 1'b1;
			else if (count_nxt == pfsd_pkg::FULL_CNT) lvl_valid_r <= 1'b0;
		end
	end

	a_ovf_set: assert property (push_req && full_w |=> buffer_overflow_flag)
		else $error("overflow not flagged");
	a_ovf_flush: assert property (overflow_clear && !push_req |=> count_r == 7'h00 && !ovf_r)
		else $error("overflow clear did not empty");
	a_flush_rx: assert property ((mode_prev_r == pfsd_pkg::MODE_SLEEP
		|| mode_prev_r == pfsd_pkg::MODE_STDBY) && chip_mode == pfsd_pkg::MODE_RX
		|=> buffer_saturated == 1'b0 && count_r == 7'h00)
		else $error("fifo kept entering receive");
	a_keep_txin: assert property (mode_chg && mode_prev_r == pfsd_pkg::MODE_STDBY
		&& chip_mode == pfsd_pkg::MODE_TX && !push_req && !overflow_clear |=> $stable(count_r))
		else $error("fifo lost entering send");
	a_level_hold: assert property (!push_ok && !pop_ok && !flush |=> $stable(lvl_r))
		else $error("level moved without access");
	a_drain_hold: assert property (host_pop ##1 (!nss_fall && !host_pop)[*2] |-> $stable(drained_r))
		else $error("drained moved before select edge");
	a_drain_set: assert property (count_r == 7'h00 && !push_ok && !rd_pend_r && !host_pop
		|=> buffer_drained)
		else $error("drained low on empty fifo");

	// ************************************************************
	// bit rate divider and transmit serializer
	// ************************************************************
	// bit period divider, runs in send and while the last send bit period drains out
	always_ff @(posedge sys_clk) begin
		if (srst || (chip_mode != pfsd_pkg::MODE_TX && !leave_tx_r) || div_r == DIV_LAST)
			div_r <= 16'h0000;
		else div_r <= div_r + 16'h0001;
	end
	assign bit_tick = div_r == DIV_LAST && chip_mode == pfsd_pkg::MODE_TX;

	// allowed payload length for the framing options
	always_comb begin
		eff_len = payload_length;
		if (crc_enable && (payload_length == 11'h000 || payload_length > pfsd_pkg::LEN_MAX_CRC))
			eff_len = pfsd_pkg::LEN_MAX_CRC;
		if (eff_len > pfsd_pkg::LEN_MAX_RAW) eff_len = pfsd_pkg::LEN_MAX_RAW;
	end

	assign sync_byte = 8'(pattern_value >> (7'h30 - {1'b0, tx_cnt_r[2:0], 3'b000}));
	assign pay_end = (eff_len != 11'h000) && (tx_cnt_r + 11'h001 == eff_len);
	assign tx_load = tx_run && bit_tick && (tx_bit_r == 3'h7) && (count_r != 7'h00)
		&& ((tx_st_r == TX_SYNC && tx_cnt_r[2:0] == pattern_length)
		|| (tx_st_r == TX_PAY && !pay_end));
	assign tx_bit_w = ((tx_st_r == TX_CRC) ? crc_tx_r[15] : tx_sr_r[7])
		^ (dc_free_enable && (tx_st_r == TX_PAY || tx_st_r == TX_CRC) && wl_tx_r[0]);

	// framer: preamble, pattern bytes, payload from the fifo, crc
	always_ff @(posedge sys_clk) begin
		if (srst || !tx_run) begin
			tx_st_r <= TX_IDLE;
			{tx_sr_r, tx_bit_r, tx_cnt_r} <= 22'h00_0000;
			crc_tx_r <= pfsd_pkg::CRC_INIT;
			wl_tx_r <= pfsd_pkg::WHITE_INIT;
		end else if (tx_st_r == TX_IDLE) begin
			if (count_r != 7'h00 && !done_r && settled_r && !mode_chg) begin
				tx_st_r <= (preamble_bytes != 8'h00) ? TX_PRE : TX_SYNC;
				tx_sr_r <= (preamble_bytes != 8'h00) ? pfsd_pkg::PREAMBLE_BYTE : pattern_value[63:56];
				crc_tx_r <= pfsd_pkg::CRC_INIT;
				wl_tx_r <= pfsd_pkg::WHITE_INIT;
			end
		end else if (bit_tick) begin
			tx_bit_r <= tx_bit_r + 3'h1;
			tx_sr_r <= {tx_sr_r[6:0], 1'b0};
			if (tx_st_r == TX_PAY || tx_st_r == TX_CRC) wl_tx_r <= pfsd_pkg::white_step(wl_tx_r);
			if (tx_st_r == TX_PAY) crc_tx_r <= pfsd_pkg::crc_step(crc_tx_r, tx_sr_r[7]);
			else if (tx_st_r == TX_CRC) crc_tx_r <= {crc_tx_r[14:0], 1'b0};
			if (tx_st_r == TX_END) tx_st_r <= TX_IDLE;
			else if (tx_bit_r == 3'h7) begin
				unique case (tx_st_r)
					TX_PRE: begin
						if (tx_cnt_r + 11'h001 < {3'h0, preamble_bytes}) begin
							tx_cnt_r <= tx_cnt_r + 11'h001;
							tx_sr_r <= pfsd_pkg::PREAMBLE_BYTE;
						end else begin
							tx_st_r <= TX_SYNC;
							tx_cnt_r <= 11'h000;
							tx_sr_r <= pattern_value[63:56];
						end
					end
					TX_SYNC: begin
						tx_cnt_r <= tx_cnt_r + 11'h001;
						tx_sr_r <= sync_byte;
						if (tx_cnt_r[2:0] == pattern_length) begin
							tx_st_r <= tx_load ? TX_PAY : TX_END;
							tx_cnt_r <= 11'h000;
							tx_sr_r <= mif.rd_data;
						end
					end
					TX_PAY: begin
						tx_cnt_r <= tx_cnt_r + 11'h001;
						tx_sr_r <= mif.rd_data;
						if (pay_end && crc_enable) begin
							tx_st_r <= TX_CRC;
							tx_cnt_r <= 11'h000;
						end else if (!tx_load) tx_st_r <= TX_END;
					end
					TX_CRC: begin
						tx_cnt_r <= 11'h001;
						if (tx_cnt_r[0]) tx_st_r <= TX_END;
					end
					default: tx_st_r <= TX_IDLE;
				endcase
			end
		end
	end

	// done goes high when the last bit period ends, low on any mode change
	always_ff @(posedge sys_clk) begin
		if (srst || mode_chg) done_r <= 1'b0;
		else if (tx_run && bit_tick && tx_st_r == TX_END) done_r <= 1'b1;
	end

	// bit to the modulator: serializer in packet mode, data pin otherwise
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mod_bit_r <= 1'b0;
			strobe_r <= 1'b0;
		end else begin
			strobe_r <= 1'b0;
			if (bit_tick && !packet_mode) begin
				mod_bit_r <= din_st_r;
				strobe_r <= 1'b1;
			end else if (bit_tick && tx_run && tx_st_r != TX_IDLE && tx_st_r != TX_END) begin
				mod_bit_r <= tx_bit_w;
				strobe_r <= 1'b1;
			end
		end
	end

	a_tx_msb: assert property (tx_run && bit_tick && tx_st_r == TX_PRE |=> mod_bit_r == $past(tx_sr_r[7]))
		else $error("serializer not msb first");
	a_tx_done: assert property (tx_run && bit_tick && tx_st_r == TX_END && !mode_chg |=> frame_tx_done)
		else $error("frame done missing");

	// ************************************************************
	// pattern detection and receive deframer
	// ************************************************************
	assign det_en = pattern_detect_enable && (packet_mode || bit_sync_enable)
		&& chip_mode == pfsd_pkg::MODE_RX;
	assign pat_bits = {1'b0, pattern_length, 3'b000} + 7'h08;
	assign pat_sh = 7'h40 - pat_bits;
	assign pat_mask = {64{1'b1}} >> pat_sh;
	assign pat_hit = det_en && pat_chk_r && (pat_cnt_r >= pat_bits)
		&& (((pat_sr_r ^ (pattern_value >> pat_sh)) & pat_mask) == 64'h0000_0000_0000_0000);

	// detector shift register, newest bit at bit 0
	always_ff @(posedge sys_clk) begin
		if (srst || !det_en) begin
			pat_sr_r <= 64'h0000_0000_0000_0000;
			pat_cnt_r <= 7'h00;
			pat_chk_r <= 1'b0;
		end else begin
			pat_chk_r <= demod_bit_valid && rx_st_r == RX_HUNT;
			if (demod_bit_valid) begin
				pat_sr_r <= {pat_sr_r[62:0], demod_bit};
				if (pat_cnt_r != 7'h40) pat_cnt_r <= pat_cnt_r + 7'h01;
			end
		end
	end

	// match flag; a new match wins over the clear
	always_ff @(posedge sys_clk) begin
		if (srst) match_r <= 1'b0;
		else if (pat_hit) match_r <= 1'b1;
		else if (chip_mode != pfsd_pkg::MODE_RX || (count_nxt == 7'h00 && count_r != 7'h00) || flush)
			match_r <= 1'b0;
	end

	assign rx_b = demod_bit ^ (dc_free_enable && wl_rx_r[0]);
	assign rx_byte = {rx_sr_r[6:0], rx_b};
	assign rx_push = rx_run && demod_bit_valid && rx_st_r == RX_PAY && rx_bit_r == 3'h7;

	// deframer: after a match gather payload bytes, then check the crc
	always_ff @(posedge sys_clk) begin
		if (srst || !rx_run) begin
			rx_st_r <= RX_HUNT;
			{rx_sr_r, rx_bit_r, rx_cnt_r} <= 22'h00_0000;
			{crc_bad_r, ready_r} <= 2'b00;
		end else begin
			ready_r <= 1'b0;
			if (rx_st_r == RX_HUNT && pat_hit) begin
				rx_st_r <= RX_PAY;
				{rx_bit_r, rx_cnt_r, crc_bad_r} <= 15'h0000;
				crc_rx_r <= pfsd_pkg::CRC_INIT;
				wl_rx_r <= pfsd_pkg::WHITE_INIT;
			end else if (demod_bit_valid && rx_st_r != RX_HUNT) begin
				rx_bit_r <= rx_bit_r + 3'h1;
				rx_sr_r <= rx_byte;
				wl_rx_r <= pfsd_pkg::white_step(wl_rx_r);
				if (rx_st_r == RX_PAY) crc_rx_r <= pfsd_pkg::crc_step(crc_rx_r, rx_b);
				else begin
					crc_rx_r <= {crc_rx_r[14:0], 1'b0};
					crc_bad_r <= crc_bad_r || (rx_b != crc_rx_r[15]);
				end
				if (rx_bit_r == 3'h7) begin
					rx_cnt_r <= rx_cnt_r + 11'h001;
					if (rx_st_r == RX_PAY && eff_len != 11'h000 && rx_cnt_r + 11'h001 == eff_len) begin
						rx_st_r <= crc_enable ? RX_CRC : RX_HUNT;
						rx_cnt_r <= 11'h000;
						ready_r <= !crc_enable;
					end else if (rx_st_r == RX_CRC && rx_cnt_r[0]) begin
						rx_st_r <= RX_HUNT;
						ready_r <= 1'b1;
					end
				end
			end
		end
	end

	// crc verdict, held until the next frame starts
	always_ff @(posedge sys_clk) begin
		if (srst || (rx_st_r == RX_HUNT && pat_hit)) crc_ok_r <= 1'b0;
		else if (rx_st_r == RX_CRC && demod_bit_valid && rx_bit_r == 3'h7 && rx_cnt_r[0])
			crc_ok_r <= !crc_bad_r && (rx_b == crc_rx_r[15]);
	end

	// raw demodulated data on the pin in bit-serial receive
	always_ff @(posedge sys_clk) begin
		if (srst) sdo_r <= 1'b0;
		else if (demod_bit_valid) sdo_r <= demod_bit;
	end

	a_match_clr: assert property (chip_mode != pfsd_pkg::MODE_RX |=> !pattern_match_flag)
		else $error("match flag kept outside receive");
	a_det_gate: assert property (!pattern_detect_enable |=> !pat_chk_r)
		else $error("detector ran while disabled");

	assign host_rdata = host_rdata_r;
	assign mod_bit = mod_bit_r;
	assign mod_bit_strobe = strobe_r;
	assign serial_data_pin_out = sdo_r;
	assign serial_data_pin_oe = !packet_mode && chip_mode == pfsd_pkg::MODE_RX;
	assign buffer_drained = drained_r;
	assign buffer_saturated = full_w;
	assign buffer_level_irq = lvl_r && lvl_valid_r;
	assign buffer_overflow_flag = ovf_r;
	assign frame_tx_done = done_r;
	assign pattern_match_flag = match_r;
	assign payload_ready = ready_r;
	assign crc_ok = crc_ok_r;
	assign mode_settled = settled_r;
endmodule : pfsd_packet_fifo
`default_nettype wire

// *** hdl/pfsd_pkg.sv ***
// shared constants for the packet fifo data path
package pfsd_pkg;
	// ************************************************************
	// fifo geometry and clocking
	// ************************************************************
	localparam int DEPTH = 64;
	localparam int AW = 6;
	localparam int CLK_HZ = 40_000_000;
	localparam int BITRATE_BPS = 4800;
	localparam logic [6:0] FULL_CNT = 7'h40;
	// ************************************************************
	// chip modes
	// ************************************************************
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STDBY = 3'h1;
	localparam logic [2:0] MODE_FSTX = 3'h2;
	localparam logic [2:0] MODE_TX = 3'h3;
	localparam logic [2:0] MODE_FSRX = 3'h4;
	localparam logic [2:0] MODE_RX = 3'h5;
	// ************************************************************
	// framing constants
	// ************************************************************
	localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [8:0] WHITE_INIT = 9'h1FF;
	localparam logic [10:0] LEN_MAX_CRC = 11'h0FF;
	localparam logic [10:0] LEN_MAX_RAW = 11'h7FF;

	// one bit of crc-16, msb first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction : crc_step

	// one step of the x^9+x^5+1 whitening sequence
	function automatic logic [8:0] white_step(input logic [8:0] w);
		white_step = {w[0] ^ w[5], w[8:1]};
	endfunction : white_step
endpackage : pfsd_pkg

// *** hdl/pfsd_mem_if.sv ***
// port bundle between the fifo control and its storage
`timescale 1ns/1ps
`default_nettype none
interface pfsd_mem_if #(
	parameter int DW = 8,
	parameter int AW = 6
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pfsd_mem_if
`default_nettype wire

// *** hdl/pfsd_mem.sv ***
// byte storage of the fifo with registered read port
`timescale 1ns/1ps
`default_nettype none
module pfsd_mem #(
	parameter int DW = 8,
	parameter int AW = 6
) (
	input wire logic sys_clk,
	pfsd_mem_if.mem m
);
	logic [DW-1:0] store_q [0:(2**AW)-1];
	logic [DW-1:0] rd_data_r;

	// write port
	always_ff @(posedge sys_clk) begin
		if (m.wr_en) begin
			store_q[m.wr_addr] <= m.wr_data;
		end
	end

	// read port, a write to the head address is passed straight through
	always_ff @(posedge sys_clk) begin
		if (m.wr_en && (m.wr_addr == m.rd_addr)) begin
			rd_data_r <= m.wr_data;
		end else begin
			rd_data_r <= store_q[m.rd_addr];
		end
	end

	assign m.rd_data = rd_data_r;
endmodule : pfsd_mem
`default_nettype wire

// *** hdl/pfsd_unused_guard.sv ***
// intentionally empty
`timescale 1ns/1ps

// *** sim/pfsd_host_model.sv ***
// host side model: one fifo read at a time, select framed after each read
`timescale 1ns/1ps
`default_nettype none
module pfsd_host_model (
	input wire logic sys_clk,
	input wire logic mode_settled,
	input wire logic rd_req,
	output logic host_rd,
	output logic spi_select_n
);
	// read waits for a settled mode, pops, then frames select for status
	initial begin
		host_rd = 1'b0;
		spi_select_n = 1'b1;
		forever begin
			@(posedge sys_clk);
			if (rd_req && mode_settled) begin
				host_rd <= 1'b1;
				@(posedge sys_clk);
				host_rd <= 1'b0;
				spi_select_n <= 1'b0;
				repeat (6) @(posedge sys_clk);
				spi_select_n <= 1'b1;
			end
		end
	end
endmodule : pfsd_host_model
`default_nettype wire

// *** sim/pfsd_packet_fifo_tb.sv ***
// self-checking bench for the packet fifo data path
`timescale 1ns/1ps
`default_nettype none
module pfsd_packet_fifo_tb;
	logic sys_clk, srst, packet_mode, host_wr, host_rd, spi_select_n, overflow_clear, rd_req;
	logic pattern_detect_enable, demod_bit, demod_bit_valid, mod_bit, mod_bit_strobe;
	logic buffer_drained, buffer_saturated, buffer_level_irq, buffer_overflow_flag;
	logic frame_tx_done, pattern_match_flag, mode_settled;
	logic [2:0] chip_mode, pattern_length;
	logic [7:0] host_wdata, host_rdata, preamble_bytes;
	logic [5:0] level_threshold;
	logic [63:0] pattern_value;
	logic [10:0] payload_length;
	logic [23:0] got;
	int fails, total_checks, cycles;
	pfsd_packet_fifo #(.BIT_DIV(4)) pfsd_packet_fifo_inst (.sys_clk(sys_clk), .srst(srst),
		.chip_mode(chip_mode), .packet_mode(packet_mode), .bit_sync_enable(1'b0),
		.crc_enable(1'b0), .dc_free_enable(1'b0), .preamble_bytes(preamble_bytes),
		.payload_length(payload_length), .host_wr(host_wr), .host_wdata(host_wdata),
		.host_rd(host_rd), .host_rdata(host_rdata), .spi_select_n(spi_select_n),
		.overflow_clear(overflow_clear), .level_threshold(level_threshold),
		.pattern_detect_enable(pattern_detect_enable), .pattern_length(pattern_length),
		.pattern_value(pattern_value), .demod_bit(demod_bit), .demod_bit_valid(demod_bit_valid),
		.mod_bit(mod_bit), .mod_bit_strobe(mod_bit_strobe), .serial_data_pin_in(1'b0),
		.serial_data_pin_out(), .serial_data_pin_oe(), .buffer_drained(buffer_drained),
		.buffer_saturated(buffer_saturated), .buffer_level_irq(buffer_level_irq),
		.buffer_overflow_flag(buffer_overflow_flag), .frame_tx_done(frame_tx_done),
		.pattern_match_flag(pattern_match_flag), .payload_ready(), .crc_ok(),
		.mode_settled(mode_settled));
	pfsd_host_model pfsd_host_model_inst (.sys_clk(sys_clk), .mode_settled(mode_settled),
		.rd_req(rd_req), .host_rd(host_rd), .spi_select_n(spi_select_n));
	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [7:0] b);
		@(posedge sys_clk) host_wr <= 1'b1;
		host_wdata <= b;
		@(posedge sys_clk) host_wr <= 1'b0;
		#1;
	endtask : wr
	task mode(input logic [2:0] m);
		@(posedge sys_clk) chip_mode <= m;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : mode
	task rd();
		@(posedge sys_clk) rd_req <= 1'b1;
		@(posedge sys_clk) rd_req <= 1'b0;
		repeat (10) @(posedge sys_clk);
		#1;
	endtask : rd
	task send(input logic b);
		@(posedge sys_clk) demod_bit <= b;
		demod_bit_valid <= 1'b1;
		@(posedge sys_clk) demod_bit_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : send
	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// ************************************************************
	// scenarios
	// ************************************************************
	task fill_test();
		level_threshold <= 6'h0A;
		mode(pfsd_pkg::MODE_STDBY);
		for (int i = 0; i < 64; i++) begin
			wr(i[7:0]);
			if (i == 9 || i == 10) check(buffer_level_irq, i == 10);
		end
		check(buffer_saturated, 1'b1);
		check(buffer_level_irq, 1'b0);
		wr(8'hEE);
		check(buffer_overflow_flag, 1'b1);
		@(posedge sys_clk) overflow_clear <= 1'b1;
		@(posedge sys_clk) overflow_clear <= 1'b0;
		#1;
		check({buffer_overflow_flag, buffer_saturated, buffer_drained}, 8'h01);
		$display("fill test done");
	endtask : fill_test
	task flush_test();
		level_threshold <= 6'h01;
		wr(8'hAB);
		wr(8'hCD);
		check(buffer_level_irq, 1'b1);
		level_threshold <= 6'h05;
		mode(pfsd_pkg::MODE_SLEEP);
		check(buffer_level_irq, 1'b1);
		check(buffer_drained, 1'b0);
		mode(pfsd_pkg::MODE_RX);
		check(buffer_drained, 1'b1);
		$display("flush test done");
	endtask : flush_test
	task tx_test();
		preamble_bytes <= 8'h01;
		mode(pfsd_pkg::MODE_STDBY);
		wr(8'h96);
		@(posedge sys_clk) chip_mode <= pfsd_pkg::MODE_TX;
		for (int i = 0; i < 24; i++) begin
			for (int n = 0; n < 40 && mod_bit_strobe !== 1'b1; n++) begin
				@(posedge sys_clk);
				#1;
			end
			got = {got[22:0], mod_bit};
			if (i < 23) begin
				@(posedge sys_clk);
				#1;
			end
		end
		check(got[23:16], 8'hAA);
		check(got[15:8], 8'hC3);
		check(got[7:0], 8'h96);
		check(frame_tx_done, 1'b0);
		repeat (8) @(posedge sys_clk);
		#1;
		check(frame_tx_done, 1'b1);
		$display("tx test done");
	endtask : tx_test
	task rx_test();
		pattern_detect_enable <= 1'b1;
		mode(pfsd_pkg::MODE_RX);
		check(mode_settled, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			send(got[8 + i]);
			repeat (2) @(posedge sys_clk);
			#1;
			check(pattern_match_flag, i == 0);
		end
		for (int i = 7; i >= 0; i--) send(got[i]);
		check(buffer_drained, 1'b0);
		mode(pfsd_pkg::MODE_STDBY);
		check(pattern_match_flag, 1'b0);
		check(mode_settled, 1'b1);
		rd();
		check(host_rdata, 8'h96);
		check(buffer_drained, 1'b1);
		$display("rx test done");
	endtask : rx_test
	// reset then run every scenario
	initial begin
		srst = 1'b1;
		chip_mode = pfsd_pkg::MODE_SLEEP;
		packet_mode = 1'b1;
		host_wr = 1'b0;
		host_wdata = 8'h00;
		overflow_clear = 1'b0;
		rd_req = 1'b0;
		level_threshold = 6'h00;
		pattern_detect_enable = 1'b0;
		pattern_length = 3'h0;
		pattern_value = 64'hC300_0000_0000_0000;
		payload_length = 11'h001;
		preamble_bytes = 8'h00;
		demod_bit = 1'b0;
		demod_bit_valid = 1'b0;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		fill_test();
		flush_test();
		tx_test();
		rx_test();
		end_of_test();
	end
endmodule : pfsd_packet_fifo_tb
`default_nettype wire
